// [hw/acr_config_register.sv]
`default_nettype none
module acr_config_register #(
   parameter bit DUAL = 1'b1
) (
   input  wire logic             CLK,         // 40 MHz system clock
   input  wire logic             RESET,       // async, active high
   input  wire logic             SCLK,        // serial clock pin
   input  wire logic             CS_N,        // frame select pin
   input  wire logic             SDI,         // serial data in pin
   output logic                  SDO,         // serial data out
   output logic                  SDO_OE_N,    // low while driving SDO
   input  wire logic             CONV_START_N, // conversion start pin
   input  wire logic             STATUS_IN,   // status pin as chain data in
   output logic                  STATUS_OUT,  // status pin level
   output logic                  STATUS_OE_N, // low while driving status
   input  wire logic [15:0]      RESULT,      // latest conversion result
   input  wire logic             EOC,         // core converting done, high
   input  wire logic             INT_PEND,    // core interrupt level
   input  wire logic             CONVERSION_CLOCK_TICK,   // one pulse per conversion clock
   output acr_pkg::acr_cfg_t     CFG,         // stored configuration word
   output logic                  CHANNEL,     // selected input channel
   output logic                  START_CONV,  // one-cycle conversion start
   output logic                  AUTO_NAP_EN, // auto-nap in force
   output logic                  SYS_RESET    // one-cycle software reset
);
   import acr_pkg::*;

   // reset value must be a plain constant, not a function call
   localparam acr_cfg_t CFG_RST = DUAL ? acr_cfg_t'(CFG_DEFAULT)
                                       : acr_cfg_t'(CFG_DEFAULT & TAG_MASK);

   // ============================================================
   // pin synchronisers
   logic [2:0] sclk_r, cs_r, cvst_r;
   logic [1:0] sdi_r, cdi_r;
   logic       sclk_fall, cs_fall, cvst_fall;

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         sclk_r <= 3'h0;
         cs_r   <= 3'h7;
         cvst_r <= 3'h7;
         sdi_r  <= 2'h0;
         cdi_r  <= 2'h0;
      end
      else
      begin
         sclk_r <= {sclk_r[1:0], SCLK};
         cs_r   <= {cs_r[1:0], CS_N};
         cvst_r <= {cvst_r[1:0], CONV_START_N};
         sdi_r  <= {sdi_r[0], SDI};
         cdi_r  <= {cdi_r[0], STATUS_IN};
      end
   end

   assign sclk_fall = sclk_r[2] & ~sclk_r[1];
   assign cs_fall   = cs_r[2] & ~cs_r[1];
   assign cvst_fall = cvst_r[2] & ~cvst_r[1];

   // ============================================================
   // serial frame and configuration word
   acr_state_t state_r, state_nxt;
   acr_cfg_t   cfg_r, cfg_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [14:0] in_r, in_nxt;
   logic [16:0] out_r, out_nxt;
   acr_cmd_t   cmd_r, cmd_nxt;
   logic       rd_cfg_r, rd_cfg_nxt;
   logic       first_r, first_nxt;
   logic       chan_r, chan_nxt;
   logic       srst_r, srst_nxt;
   logic [3:0] cmd_in;
   logic [11:0] word_in;
   logic       fill;

   function automatic acr_cfg_t clean(input logic [11:0] w);
      clean = DUAL ? acr_cfg_t'(w) : acr_cfg_t'(w & TAG_MASK);
   endfunction : clean

   assign cmd_in  = {in_r[2:0], sdi_r[1]};
   assign word_in = {in_r[10:0], sdi_r[1]};
   // chain mode passes upstream bits through behind our own word
   assign fill    = cfg_r.status_out ? 1'b0 : cdi_r[1];

   always_comb
   begin
      state_nxt  = state_r;
      cfg_nxt    = cfg_r;
      cnt_nxt    = cnt_r;
      in_nxt     = in_r;
      out_nxt    = out_r;
      cmd_nxt    = cmd_r;
      rd_cfg_nxt = rd_cfg_r;
      first_nxt  = first_r;
      chan_nxt   = chan_r;
      srst_nxt   = 1'b0;
      case (state_r)
         ST_IDLE:
         begin
            if (cs_fall)
            begin
               state_nxt = ST_CMD;
               cnt_nxt   = 5'h00;
               // first frame after any reset shows all ones
               out_nxt   = first_r ? 17'h1_FFFF : {RESULT, chan_r};
               // spent once a frame opens; a soft reset later re-arms it
               first_nxt = 1'b0;
            end
         end
         ST_CMD, ST_DATA:
         begin
            if (sclk_fall)
            begin
               cnt_nxt = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 5'h01;
               in_nxt  = {in_r[13:0], sdi_r[1]};
               out_nxt = {out_r[15:0], fill};
               if (!cfg_r.tag_en && cnt_r == WORD_LAST)
                  out_nxt[16] = fill;
               if (cnt_r == CMD_LAST)
               begin
                  state_nxt = ST_DATA;
                  cmd_nxt   = acr_cmd_t'(cmd_in);
                  case (cmd_in)
                     CMD_CH0: if (DUAL) chan_nxt = 1'b0;
                     CMD_CH1: if (DUAL) chan_nxt = 1'b1;
                     CMD_WAKE:
                     begin
                        cfg_nxt.nap_off  = 1'b1;
                        cfg_nxt.deep_off = 1'b1;
                     end
                     CMD_RD_CFG:
                     begin
                        rd_cfg_nxt = 1'b1;
                        // tag rides behind the word and lands on the 17th clock
                        out_nxt    = {cfg_r, chan_r, out_r[2:0], fill};
                     end
                     CMD_DEFAULT: cfg_nxt = clean(CFG_DEFAULT);
                     default: ;
                  endcase
               end
               if (cnt_r == WORD_LAST && cmd_r == CMD_WR_CFG)
               begin
                  if (!word_in[0])
                  begin
                     cfg_nxt  = clean(CFG_DEFAULT);
                     srst_nxt = 1'b1;
                  end
                  else
                     cfg_nxt = clean(word_in);
               end
            end
            if (cs_r[1])
            begin
               state_nxt  = ST_IDLE;
               rd_cfg_nxt = 1'b0;
               cmd_nxt    = CMD_RD_DATA;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (srst_r)
         first_nxt = 1'b1;
      // automatic sequencing steps channel at each start
      if (START_CONV && cfg_r.auto_chan && DUAL)
         chan_nxt = ~chan_r;
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         state_r  <= ST_IDLE;
         cfg_r    <= CFG_RST;
         cnt_r    <= 5'h00;
         in_r     <= 15'h0000;
         out_r    <= 17'h1_FFFF;
         cmd_r    <= CMD_RD_DATA;
         rd_cfg_r <= 1'b0;
         first_r  <= 1'b1;
         chan_r   <= 1'b0;
         srst_r   <= 1'b0;
      end
      else
      begin
         state_r  <= state_nxt;
         cfg_r    <= cfg_nxt;
         cnt_r    <= cnt_nxt;
         in_r     <= in_nxt;
         out_r    <= out_nxt;
         cmd_r    <= cmd_nxt;
         rd_cfg_r <= rd_cfg_nxt;
         first_r  <= first_nxt;
         chan_r   <= chan_nxt;
         srst_r   <= srst_nxt;
      end
   end

   // ============================================================
   // trigger, status pin and power controls
   logic       eoc_d_r, eoc_d_nxt;
   logic [2:0] trig_r, trig_nxt;
   logic       start_r, start_nxt;
   logic       stat_r, stat_nxt;

   always_comb
   begin
      eoc_d_nxt = EOC;
      trig_nxt  = trig_r;
      start_nxt = 1'b0;
      if (cfg_r.manual_trig)
      begin
         trig_nxt = 3'h0;
         // readback frames leave the start pin out of play
         start_nxt = cvst_fall & ~rd_cfg_r;
      end
      else if (eoc_d_r && !EOC)
         trig_nxt = AUTO_TRIG_CCLKS;
      else if (CONVERSION_CLOCK_TICK && trig_r != 3'h0)
      begin
         trig_nxt  = trig_r - 3'h1;
         start_nxt = (trig_r == 3'h1);
      end
      stat_nxt = (cfg_r.func_eoc ? EOC : INT_PEND) & ~rd_cfg_r;
      stat_nxt = stat_nxt ^ cfg_r.pol_low;
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         eoc_d_r <= 1'b0;
         trig_r  <= 3'h0;
         start_r <= 1'b0;
         stat_r  <= 1'b0;
      end
      else
      begin
         eoc_d_r <= eoc_d_nxt;
         trig_r  <= trig_nxt;
         start_r <= start_nxt;
         stat_r  <= stat_nxt;
      end
   end

   assign SDO         = out_r[16];
   assign SDO_OE_N    = (state_r == ST_IDLE);
   assign STATUS_OUT  = stat_r;
   assign STATUS_OE_N = ~cfg_r.status_out;
   assign CFG         = cfg_r;
   assign CHANNEL     = chan_r;
   assign START_CONV  = start_r;
   assign AUTO_NAP_EN = cfg_r.manual_trig & ~cfg_r.anap_off;
   assign SYS_RESET   = srst_r;

   // ============================================================
   // checks
   a_write_takes: assert property (@(posedge CLK) disable iff (RESET)
      (sclk_fall && cnt_r == WORD_LAST && cmd_r == CMD_WR_CFG && word_in[0]
       && state_r != ST_IDLE && !cs_r[1])
      |=> (cfg_r == clean($past(word_in))))
      else $error("configuration write not applied");
   a_default_load: assert property (@(posedge CLK) disable iff (RESET)
      (sclk_fall && cnt_r == CMD_LAST && cmd_in == 4'hF && state_r != ST_IDLE)
      |=> (cfg_r == clean(CFG_DEFAULT)))
      else $error("default command did not load defaults");
   a_wake_sets: assert property (@(posedge CLK) disable iff (RESET)
      (sclk_fall && cnt_r == CMD_LAST && cmd_in == 4'hB && state_r != ST_IDLE)
      |=> (cfg_r.nap_off && cfg_r.deep_off))
      else $error("wake-up left a power-down bit clear");
   a_soft_reset: assert property (@(posedge CLK) disable iff (RESET)
      (sclk_fall && cnt_r == WORD_LAST && cmd_r == CMD_WR_CFG && !word_in[0]
       && state_r != ST_IDLE && !cs_r[1])
      |=> (SYS_RESET && cfg_r.run) ##1 !SYS_RESET)
      else $error("reset bit write did not pulse reset");
   a_readback_word: assert property (@(posedge CLK) disable iff (RESET)
      (sclk_fall && cnt_r == CMD_LAST && cmd_in == 4'hC && state_r != ST_IDLE)
      |=> (out_r[16:5] == $past(cfg_r) && rd_cfg_r))
      else $error("readback word not loaded");
   a_status_quiet: assert property (@(posedge CLK) disable iff (RESET)
      rd_cfg_r ##1 rd_cfg_r |-> (STATUS_OUT == cfg_r.pol_low))
      else $error("status active during readback");
   // automatic trigger does not use the start pin, so only manual starts are barred
   a_start_quiet: assert property (@(posedge CLK) disable iff (RESET)
      (rd_cfg_r && cfg_r.manual_trig) |=> !START_CONV)
      else $error("start pin honoured during readback");
   a_nap_gate: assert property (@(posedge CLK) disable iff (RESET)
      !cfg_r.manual_trig |-> !AUTO_NAP_EN)
      else $error("auto-nap active under automatic trigger");
   a_tag_single: assert property (@(posedge CLK) disable iff (RESET)
      !DUAL |-> !cfg_r.tag_en)
      else $error("tag bit set on single-channel variant");
   a_auto_start: assert property (@(posedge CLK) disable iff (RESET)
      (!cfg_r.manual_trig && eoc_d_r && !EOC) |=> (trig_r == AUTO_TRIG_CCLKS))
      else $error("automatic trigger count not armed");
endmodule : acr_config_register
`default_nettype wire

// [inc/acr_pkg.sv]
`default_nettype none
package acr_pkg;
   // ============================================================
   // configuration word layout, D11 down to D0
   typedef struct packed {
      logic auto_chan;   // D11
      logic conversion_clock_int;    // D10
      logic manual_trig; // D9
      logic spare;       // D8
      logic pol_low;     // D7
      logic func_eoc;    // D6
      logic status_out;  // D5
      logic anap_off;    // D4
      logic nap_off;     // D3
      logic deep_off;    // D2
      logic tag_en;      // D1
      logic run;         // D0
   } acr_cfg_t;

   localparam logic [11:0] CFG_DEFAULT = 12'hEFF;
   localparam logic [11:0] TAG_MASK    = 12'hFFD;

   // ============================================================
   // commands and frame states
   typedef enum logic [3:0] {
      CMD_CH0     = 4'h0,
      CMD_CH1     = 4'h1,
      CMD_WAKE    = 4'hB,
      CMD_RD_CFG  = 4'hC,
      CMD_RD_DATA = 4'hD,
      CMD_WR_CFG  = 4'hE,
      CMD_DEFAULT = 4'hF
   } acr_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD  = 2'b01,
      ST_DATA = 2'b10
   } acr_state_t;

   // ============================================================
   // counts of serial clock falling edges and conversion clocks
   localparam logic [4:0] CMD_LAST  = 5'h03;
   localparam logic [4:0] WORD_LAST = 5'h0F;
   localparam logic [4:0] CNT_MAX   = 5'h1F;
   localparam logic [2:0] AUTO_TRIG_CCLKS = 3'h4;
endpackage : acr_pkg
`default_nettype wire

// [tb/acr_host.sv]
`default_nettype none
module acr_host (
   input  wire logic clk,  // system clock
   input  wire logic sdo,  // serial data from device
   output logic      sclk, // serial clock, idles high
   output logic      cs_n, // frame select
   output logic      sdi   // serial data to device
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      sclk = 1'b1;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end
   // ==========================================================
   // one frame, four cycles of clk per sclk level
   task automatic frame(input logic [3:0] cmd, input logic [11:0] data, input int nbits,
                        output logic [16:0] got);
      logic [16:0] word;
      word = {cmd, data, 1'b0};
      got  = '0;
      @(posedge clk) cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < nbits; i++)
      begin
         sdi <= word[16-i];
         repeat (4) @(posedge clk);
         got[16-i] = sdo;
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      // released line must not keep its last value
      sdi  <= ~sdi;
      repeat (6) @(posedge clk);
   endtask : frame
endmodule : acr_host
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import acr_pkg::*;
   logic        clk, rst, sclk, cs_n, sdi, sdo, conv_n, status_in, status_out, status_oe_n;
   logic        eoc, int_pend, tick, channel, start_conv, auto_nap, sys_rst, sdo_oe_n;
   logic [15:0] result;
   acr_cfg_t    cfg, cfg1;
   logic [16:0] got;
   int          n_errors = 0, n_checks = 0, n_starts = 0, n_resets = 0, cycles = 0;
   acr_host host (.clk(clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
   acr_config_register #(.DUAL(1'b1)) dut (
      .CLK(clk), .RESET(rst), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo),
      .SDO_OE_N(sdo_oe_n), .CONV_START_N(conv_n), .STATUS_IN(status_in),
      .STATUS_OUT(status_out), .STATUS_OE_N(status_oe_n), .RESULT(result), .EOC(eoc),
      .INT_PEND(int_pend), .CONVERSION_CLOCK_TICK(tick), .CFG(cfg), .CHANNEL(channel),
      .START_CONV(start_conv), .AUTO_NAP_EN(auto_nap), .SYS_RESET(sys_rst));
   acr_config_register #(.DUAL(1'b0)) dut_single (
      .CLK(clk), .RESET(rst), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(),
      .SDO_OE_N(), .CONV_START_N(conv_n), .STATUS_IN(status_in),
      .STATUS_OUT(), .STATUS_OE_N(), .RESULT(result), .EOC(eoc),
      .INT_PEND(int_pend), .CONVERSION_CLOCK_TICK(tick), .CFG(cfg1), .CHANNEL(),
      .START_CONV(), .AUTO_NAP_EN(), .SYS_RESET());
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ==========================================================
   // helpers
   task automatic end_sim();
      if (n_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [11:0] v);
      host.frame(CMD_WR_CFG, v, 16, got);
   endtask : wr
   task automatic rd(input int n);
      host.frame(CMD_RD_CFG, 12'h000, n, got);
   endtask : rd
   task automatic pulse(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk) tick <= 1'b1;
         @(posedge clk) tick <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask : pulse
   always @(posedge clk)
   begin
      cycles++;
      if (start_conv === 1'b1)
         n_starts++;
      if (sys_rst === 1'b1)
         n_resets++;
      // a hung frame counts as a failure
      if (cycles == 8000)
      begin
         n_errors++;
         end_sim();
      end
   end
   // ==========================================================
   // main sequence
   initial
   begin
      rst = 1'b1;
      conv_n = 1'b1;
      status_in = 1'b0;
      eoc = 1'b0;
      int_pend = 1'b0;
      tick = 1'b0;
      result = 16'h93C5;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check("cfg", cfg, CFG_DEFAULT);
      check("single cfg", cfg1, CFG_DEFAULT & TAG_MASK);
      check("status oe", status_oe_n, 1'b0);
      check("sdo oe idle", sdo_oe_n, 1'b1);
      rd(17);
      check("first nibble", got[16:13], 4'hF);
      check("readback", got[12:1], CFG_DEFAULT);
      check("tag ch0", got[0], 1'b0);
      host.frame(CMD_CH1, 12'h000, 4, got);
      check("channel", channel, 1'b1);
      rd(17);
      check("result nibble", got[16:13], 4'h9);
      check("tag ch1", got[0], 1'b1);
      eoc <= 1'b1;
      wr(12'h26F);
      check("cfg", cfg, 12'h26F);
      check("single cfg", cfg1, 12'h26D);
      check("auto nap", auto_nap, 1'b1);
      check("status", status_out, 1'b1);
      fork
         rd(16);
         begin
            repeat (60) @(posedge clk);
            conv_n <= 1'b0;
            check("status in read", status_out, 1'b0);
            check("sdo oe read", sdo_oe_n, 1'b0);
            repeat (8) @(posedge clk);
            conv_n <= 1'b1;
         end
      join
      check("readback", got[12:1], 12'h26F);
      @(posedge clk) conv_n <= 1'b0;
      repeat (8) @(posedge clk);
      conv_n <= 1'b1;
      check("manual starts", n_starts, 1);
      check("channel kept", channel, 1'b1);
      host.frame(CMD_CH0, 12'h000, 4, got);
      check("channel 0", channel, 1'b0);
      wr(12'h2ED);
      check("status low", status_out, 1'b0);
      wr(12'h2AD);
      check("status int", status_out, 1'b1);
      wr(12'h24D);
      check("chain oe", status_oe_n, 1'b1);
      status_in <= 1'b1;
      host.frame(CMD_RD_DATA, 12'h000, 17, got);
      check("chain fill", got[0], 1'b1);
      status_in <= 1'b0;
      wr(12'h86D);
      check("auto nap off", auto_nap, 1'b0);
      check("conversion_clock src", cfg.conversion_clock_int, 1'b0);
      @(posedge clk) eoc <= 1'b0;
      pulse(3);
      check("early start", n_starts, 1);
      pulse(1);
      check("auto start", n_starts, 2);
      check("auto channel", channel, 1'b1);
      wr(12'h2E1);
      check("nap", cfg.nap_off, 1'b0);
      host.frame(CMD_WAKE, 12'h000, 4, got);
      check("woken", cfg, 12'h2ED);
      host.frame(CMD_DEFAULT, 12'h000, 4, got);
      check("default", cfg, CFG_DEFAULT);
      wr(12'h2EC);
      check("soft reset cfg", cfg, CFG_DEFAULT);
      check("soft resets", n_resets, 1);
      rd(16);
      check("ones after reset", got[16:13], 4'hF);
      end_sim();
   end
endmodule : tb
`default_nettype wire
